/* File: rtl/nfc_pkg.sv */
// Purpose: constants for the numeric format converter
// Assumes: one clock, single-precision float as the internal carrier
// Notes: opcodes select one conversion per accepted word
package nfc_pkg;
    localparam logic [3:0] OP_DEC_F16 = 4'h0;
    localparam logic [3:0] OP_DEC_F11 = 4'h1;
    localparam logic [3:0] OP_DEC_F10 = 4'h2;
    localparam logic [3:0] OP_ENC_F11 = 4'h3;
    localparam logic [3:0] OP_ENC_F10 = 4'h4;
    localparam logic [3:0] OP_UNORM_TO_F = 4'h5;
    localparam logic [3:0] OP_SNORM_TO_F = 4'h6;
    localparam logic [3:0] OP_F_TO_UNORM = 4'h7;
    localparam logic [3:0] OP_F_TO_SNORM = 4'h8;
    localparam logic [3:0] OP_FIX_TO_F = 4'h9;
    localparam int F16_SIGN_BIT = 15;
    localparam int F16_EXP_LO = 10;
    localparam int F16_MAN_W = 10;
    localparam int F11_MAN_W = 6;
    localparam int F10_MAN_W = 5;
    localparam int SMALL_EXP_W = 5;
    localparam int SMALL_EXP_TOP = 30;
    localparam int SMALL_EXP_SPECIAL = 31;
    localparam int SMALL_BIAS = 15;
    localparam int SUB_SCALE = -14;
    localparam int SP_BIAS = 127;
    localparam int SP_MAN_W = 23;
    localparam logic [7:0] SP_EXP_SPECIAL = 8'hff;
    localparam logic [31:0] SP_ONE = 32'h3f800000;
    localparam logic [31:0] SP_QNAN = 32'h7fc00000;
    localparam logic [10:0] F11_MAX = 11'h7bf;
    localparam logic [9:0] F10_MAX = 10'h3df;
    localparam int FIX_FRAC_W = 16;
    localparam int NORM_SCALE = -32;
    localparam int FX_ALIGN = 134;
    localparam int ALPHA_MIN_W = 2;
    localparam int DEF_NORM_W = 8;
    localparam int LATENCY = 2;
endpackage : nfc_pkg

/* File: rtl/nfc_norm.sv */
// Purpose: turn a magnitude and binary scale into a single float
// Assumes: result exponent stays inside the normal single range
// Notes: truncates bits below the 23-bit fraction
`timescale 1ns/100ps
`default_nettype none
module nfc_norm (
    input wire logic [31:0] mag,
    input wire logic signed [7:0] scale,
    input wire logic sign,
    output logic [31:0] fp
);
    logic [4:0] msb;
    logic [31:0] shifted;
    logic [7:0] ex;

    // leading one search and left alignment
    always_comb begin
        msb = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (mag[i]) begin
                msb = 5'(i);
            end
        end
        shifted = mag << (5'h1f - msb);
        ex = 8'(int'(scale) + nfc_pkg::SP_BIAS + int'(msb));
        // zero magnitude keeps its sign, no divide involved
        if (mag == 32'h00000000) begin
            fp = {sign, 31'h00000000};
        end else begin
            fp = {sign, ex, shifted[30:8]};
        end
    end
endmodule : nfc_norm
`default_nettype wire

/* File: rtl/nfc_conv.sv */
// Purpose: fixed-latency converter between small floats, normalized
//          integers, 16.16 fixed point and single floats
// Assumes: one operation per valid cycle, result two edges later
// Notes: normalized values sit in the low bits, upper bits zero
`timescale 1ns/100ps
`default_nettype none
module nfc_conv #(
    parameter int NORM_W = nfc_pkg::DEF_NORM_W,
    parameter bit ALPHA_PATH = 1'b0,
    parameter bit ROUND_NEAREST = 1'b1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [3:0] in_op,
    input wire logic [31:0] in_data,
    output logic out_valid,
    output logic [31:0] out_data
);
    // width b, raised for alpha
    localparam int BW = (ALPHA_PATH && NORM_W < nfc_pkg::ALPHA_MIN_W) ?
        nfc_pkg::ALPHA_MIN_W : NORM_W;
    localparam logic [BW-1:0] UMAX = {BW{1'b1}};
    localparam logic [BW-2:0] SMAX = {(BW-1){1'b1}};

    ////////////////////////////////////////////////////////////////////
    // encoder to unsigned small float

    function automatic logic [10:0] enc_small(
        input logic [31:0] f,
        input int mw,
        input logic rne
    );
        int te;
        int sh;
        int pk;
        int mx;
        logic [23:0] full;
        logic [23:0] q;
        logic rb;
        mx = (nfc_pkg::SMALL_EXP_TOP << mw) | ((1 << mw) - 1);
        full = {1'b1, f[22:0]};
        te = int'(f[30:23]) - nfc_pkg::SP_BIAS + nfc_pkg::SMALL_BIAS;
        q = 24'h000000;
        rb = 1'b0;
        pk = 0;
        if (f[30:23] == nfc_pkg::SP_EXP_SPECIAL) begin
            if (f[22:0] != 23'h000000) begin
                pk = (nfc_pkg::SMALL_EXP_SPECIAL << mw) | (1 << (mw - 1));
            end else if (f[31]) begin
                pk = 0;
            end else begin
                pk = nfc_pkg::SMALL_EXP_SPECIAL << mw;
            end
        end else if (f[31] || f[30:23] == 8'h00) begin
            pk = 0;
        end else if (te > nfc_pkg::SMALL_EXP_TOP) begin
            pk = mx;
        end else begin
            sh = (te >= 1) ? (nfc_pkg::SP_MAN_W - mw) : (nfc_pkg::SP_MAN_W + 1 - mw - te);
            if (sh <= 24) begin
                q = full >> sh;
                rb = full[sh-1];
            end
            pk = ((te >= 1) ? ((te - 1) << mw) : 0) + int'(q) + ((rne && rb) ? 1 : 0);
            if (pk > mx) begin
                pk = mx;
            end
        end
        return 11'(pk);
    endfunction : enc_small

    ////////////////////////////////////////////////////////////////////
    // decode of special and normal small floats

    function automatic logic [31:0] dec_small(
        input logic s,
        input logic [4:0] e,
        input logic [22:0] man,
        input logic [31:0] sub_fp
    );
        logic [31:0] r;
        if (e == 5'h00) begin
            r = sub_fp;
        end else if (int'(e) == nfc_pkg::SMALL_EXP_SPECIAL) begin
            r = (man == 23'h000000) ? {s, nfc_pkg::SP_EXP_SPECIAL, 23'h000000} :
                nfc_pkg::SP_QNAN;
        end else begin
            r = {s, 8'(int'(e) - nfc_pkg::SMALL_BIAS + nfc_pkg::SP_BIAS), man};
        end
        return r;
    endfunction : dec_small

    ////////////////////////////////////////////////////////////////////
    // stage one: capture request

    logic s1_valid;
    logic [3:0] s1_op;
    logic [31:0] s1_data;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_valid <= 1'b0;
            s1_op <= 4'h0;
            s1_data <= 32'h00000000;
        end else begin
            s1_valid <= in_valid;
            s1_op <= in_op;
            s1_data <= in_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // field extraction

    logic h_sign;
    logic [4:0] h_exp;
    logic [9:0] h_man;
    logic [4:0] e11;
    logic [5:0] m11;
    logic [4:0] e10;
    logic [4:0] m10;

    assign h_sign = s1_data[nfc_pkg::F16_SIGN_BIT];
    assign h_exp = s1_data[nfc_pkg::F16_EXP_LO +: nfc_pkg::SMALL_EXP_W];
    assign h_man = s1_data[nfc_pkg::F16_MAN_W-1:0];
    assign e11 = s1_data[nfc_pkg::F11_MAN_W +: nfc_pkg::SMALL_EXP_W];
    assign m11 = s1_data[nfc_pkg::F11_MAN_W-1:0];
    assign e10 = s1_data[nfc_pkg::F10_MAN_W +: nfc_pkg::SMALL_EXP_W];
    assign m10 = s1_data[nfc_pkg::F10_MAN_W-1:0];

    ////////////////////////////////////////////////////////////////////
    // normalized integer to float: repeating pattern equals c/(2^n-1)

    logic [BW-1:0] cu;
    logic [BW-1:0] cs;
    logic [BW-1:0] cs_abs;
    logic [31:0] rep_u;
    logic [31:0] rep_s;

    assign cu = s1_data[BW-1:0];
    assign cs = s1_data[BW-1:0];
    assign cs_abs = cs[BW-1] ? (~cs + {{(BW-1){1'b0}}, 1'b1}) : cs;

    for (genvar gi = 0; gi < 32; gi++) begin : g_rep
        assign rep_u[31-gi] = cu[BW-1-(gi % BW)];
        assign rep_s[31-gi] = cs_abs[BW-2-(gi % (BW-1))];
    end

    ////////////////////////////////////////////////////////////////////
    // shared normalizer

    logic [31:0] nm_mag;
    logic signed [7:0] nm_scale;
    logic nm_sign;
    logic [31:0] nm_fp;

    always_comb begin
        nm_mag = 32'h00000000;
        nm_scale = 8'sh00;
        nm_sign = 1'b0;
        case (s1_op)
            nfc_pkg::OP_DEC_F16: begin
                nm_mag = {22'h000000, h_man};
                nm_scale = 8'(nfc_pkg::SUB_SCALE - nfc_pkg::F16_MAN_W);
                nm_sign = h_sign;
            end
            nfc_pkg::OP_DEC_F11: begin
                nm_mag = {26'h0000000, m11};
                nm_scale = 8'(nfc_pkg::SUB_SCALE - nfc_pkg::F11_MAN_W);
            end
            nfc_pkg::OP_DEC_F10: begin
                nm_mag = {27'h0000000, m10};
                nm_scale = 8'(nfc_pkg::SUB_SCALE - nfc_pkg::F10_MAN_W);
            end
            nfc_pkg::OP_UNORM_TO_F: begin
                nm_mag = rep_u;
                nm_scale = 8'(nfc_pkg::NORM_SCALE);
            end
            nfc_pkg::OP_SNORM_TO_F: begin
                nm_mag = rep_s;
                nm_scale = 8'(nfc_pkg::NORM_SCALE);
                nm_sign = cs[BW-1];
            end
            nfc_pkg::OP_FIX_TO_F: begin
                nm_mag = s1_data[31] ? (~s1_data + 32'h00000001) : s1_data;
                nm_scale = 8'(-nfc_pkg::FIX_FRAC_W);
                nm_sign = s1_data[31];
            end
            default: begin
                nm_mag = 32'h00000000;
            end
        endcase
    end

    nfc_norm u_norm (
        .mag(nm_mag),
        .scale(nm_scale),
        .sign(nm_sign),
        .fp(nm_fp)
    );

    ////////////////////////////////////////////////////////////////////
    // float to normalized integer

    logic f_sign;
    logic [7:0] f_exp;
    logic f_nan;
    logic [7:0] fx_sh;
    logic [39:0] fx;
    logic [63:0] prod_u;
    logic [63:0] prod_s;
    logic [BW-1:0] q_u;
    logic [BW-1:0] q_s;
    logic [BW-2:0] mag_s;

    assign f_sign = s1_data[31];
    assign f_exp = s1_data[30:23];
    assign f_nan = (f_exp == nfc_pkg::SP_EXP_SPECIAL) && (s1_data[22:0] != 23'h000000);
    assign fx_sh = 8'(nfc_pkg::FX_ALIGN - int'(f_exp));

    always_comb begin
        // fraction of a value below one, 32 fraction bits
        if (f_exp == 8'h00 || fx_sh >= 8'd40) begin
            fx = 40'h0000000000;
        end else begin
            fx = {1'b1, s1_data[22:0], 16'h0000} >> fx_sh;
        end
        prod_u = ({24'h000000, fx} << BW) - {24'h000000, fx} + 64'h0000000080000000;
        prod_s = ({24'h000000, fx} << (BW - 1)) - {24'h000000, fx} + 64'h0000000080000000;
        // clamp to [0,1]
        if (f_nan || f_sign || f_exp == 8'h00) begin
            q_u = {BW{1'b0}};
        end else if (int'(f_exp) >= nfc_pkg::SP_BIAS) begin
            q_u = UMAX;
        end else begin
            q_u = prod_u[32 +: BW];
        end
        // clamp to [-1,1], then two's complement in b bits
        if (f_nan || f_exp == 8'h00) begin
            mag_s = {(BW-1){1'b0}};
        end else if (int'(f_exp) >= nfc_pkg::SP_BIAS) begin
            mag_s = SMAX;
        end else begin
            mag_s = prod_s[32 +: (BW-1)];
        end
        q_s = f_sign ? (~{1'b0, mag_s} + {{(BW-1){1'b0}}, 1'b1}) : {1'b0, mag_s};
    end

    ////////////////////////////////////////////////////////////////////
    // result select

    logic [31:0] next_data;
    logic [10:0] enc11;
    logic [10:0] enc10;

    assign enc11 = enc_small(s1_data, nfc_pkg::F11_MAN_W, ROUND_NEAREST);
    assign enc10 = enc_small(s1_data, nfc_pkg::F10_MAN_W, ROUND_NEAREST);

    always_comb begin
        case (s1_op)
            nfc_pkg::OP_DEC_F16: begin
                next_data = dec_small(h_sign, h_exp, {h_man, 13'h0000}, nm_fp);
            end
            nfc_pkg::OP_DEC_F11: begin
                next_data = dec_small(1'b0, e11, {m11, 17'h00000}, nm_fp);
            end
            nfc_pkg::OP_DEC_F10: begin
                next_data = dec_small(1'b0, e10, {m10, 18'h00000}, nm_fp);
            end
            nfc_pkg::OP_ENC_F11: begin
                next_data = {21'h000000, enc11};
            end
            nfc_pkg::OP_ENC_F10: begin
                next_data = {22'h000000, enc10[9:0]};
            end
            nfc_pkg::OP_UNORM_TO_F: begin
                next_data = (cu == UMAX) ? nfc_pkg::SP_ONE : nm_fp;
            end
            nfc_pkg::OP_SNORM_TO_F: begin
                // most negative code also clamps to -1.0
                next_data = (cs_abs[BW-1] || cs_abs[BW-2:0] == SMAX) ?
                    {cs[BW-1], nfc_pkg::SP_ONE[30:0]} : nm_fp;
            end
            nfc_pkg::OP_F_TO_UNORM: begin
                next_data = {{(32-BW){1'b0}}, q_u};
            end
            nfc_pkg::OP_F_TO_SNORM: begin
                next_data = {{(32-BW){1'b0}}, q_s};
            end
            nfc_pkg::OP_FIX_TO_F: begin
                next_data = nm_fp;
            end
            default: begin
                next_data = 32'h00000000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // stage two: output registers

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= 32'h00000000;
        end else begin
            out_valid <= s1_valid;
            out_data <= s1_valid ? next_data : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    chk_valid_latency: assert property (@(posedge mclk) disable iff (!rst_n)
        in_valid |-> ##2 out_valid)
        else $error("valid not returned after two edges");

    chk_no_phantom: assert property (@(posedge mclk) disable iff (!rst_n)
        !in_valid |-> ##2 !out_valid)
        else $error("output valid without request");

    chk_f16_normal: assert property (@(posedge mclk) disable iff (!rst_n)
        (in_valid && in_op == nfc_pkg::OP_DEC_F16 && in_data[14:10] != 5'h00
         && in_data[14:10] != 5'h1f)
        |-> ##2 (out_data[30:23] == 8'(int'($past(in_data[14:10], 2)) + 112)
                 && out_data[31] == $past(in_data[15], 2)
                 && out_data[22:13] == $past(in_data[9:0], 2)))
        else $error("half normal decode wrong");

    chk_f16_negzero: assert property (@(posedge mclk) disable iff (!rst_n)
        (in_valid && in_op == nfc_pkg::OP_DEC_F16 && in_data[15:0] == 16'h8000)
        |-> ##2 out_data == 32'h80000000)
        else $error("negative zero not kept");

    chk_f11_clamp: assert property (@(posedge mclk) disable iff (!rst_n)
        (in_valid && in_op == nfc_pkg::OP_ENC_F11 && !in_data[31]
         && in_data[30:23] >= 8'h8f && in_data[30:23] != 8'hff)
        |-> ##2 out_data == 32'h000007bf)
        else $error("11-bit clamp not 65024");

    chk_f10_neginf: assert property (@(posedge mclk) disable iff (!rst_n)
        (in_valid && in_op == nfc_pkg::OP_ENC_F10 && in_data == 32'hff800000)
        |-> ##2 out_data == 32'h00000000)
        else $error("negative infinity not zero");

    chk_f11_nan: assert property (@(posedge mclk) disable iff (!rst_n)
        (in_valid && in_op == nfc_pkg::OP_ENC_F11 && in_data[30:23] == 8'hff
         && in_data[22:0] != 23'h000000)
        |-> ##2 (out_data[10:6] == 5'h1f && out_data[5:0] != 6'h00))
        else $error("nan not positive nan");

    chk_unorm_one: assert property (@(posedge mclk) disable iff (!rst_n)
        (in_valid && in_op == nfc_pkg::OP_UNORM_TO_F && in_data[BW-1:0] == UMAX)
        |-> ##2 out_data == 32'h3f800000)
        else $error("full code not 1.0");

    chk_snorm_floor: assert property (@(posedge mclk) disable iff (!rst_n)
        (in_valid && in_op == nfc_pkg::OP_SNORM_TO_F
         && in_data[BW-1:0] == {1'b1, {(BW-1){1'b0}}})
        |-> ##2 out_data == 32'hbf800000)
        else $error("most negative code not -1.0");

    chk_unorm_clamp: assert property (@(posedge mclk) disable iff (!rst_n)
        (in_valid && in_op == nfc_pkg::OP_F_TO_UNORM && !in_data[31]
         && in_data[30:23] >= 8'h7f && in_data[30:23] != 8'hff)
        |-> ##2 out_data == {{(32-BW){1'b0}}, UMAX})
        else $error("unsigned clamp at one wrong");

    chk_snorm_clamp: assert property (@(posedge mclk) disable iff (!rst_n)
        (in_valid && in_op == nfc_pkg::OP_F_TO_SNORM && in_data == 32'hc0000000)
        |-> ##2 out_data[BW-1:0] == (~{1'b0, SMAX} + {{(BW-1){1'b0}}, 1'b1}))
        else $error("signed clamp at minus one wrong");
endmodule : nfc_conv
`default_nettype wire

/* File: testbench/nfc_sink.sv */
// Purpose: consumer stage that takes every converted result
// Assumes: no back-pressure exists, so the consumer never stalls
// Notes: counts results and keeps the latest one for the bench
`timescale 1ns/100ps
`default_nettype none
module nfc_sink (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic res_valid,
    input wire logic [31:0] res_data,
    output logic [31:0] rx_count,
    output logic [31:0] rx_last
);
    // result capture on each strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_count <= 32'h0;
            rx_last <= 32'h0;
        end else if (res_valid) begin
            rx_count <= rx_count + 32'h1;
            rx_last <= res_data;
        end
    end
endmodule : nfc_sink
`default_nettype wire

/* File: testbench/nfc_conv_tb_top.sv */
// Purpose: self-checking bench for the format converter
// Assumes: two-edge latency, results zero while strobe low
// Notes: second instance runs the alpha width floor of two, small-float encoder rounding toward zero
`timescale 1ns/100ps
`default_nettype none
module nfc_conv_tb_top;
    logic mclk, rst_n, in_valid, out_valid, out_valid2;
    logic [3:0] in_op;
    logic [31:0] in_data, out_data, out_data2, exp_a, exp_b, seed, rx_count, rx_last;
    logic pv[3];
    logic [3:0] po[3];
    logic [31:0] pd[3], px[3];
    int bad_count = 0;
    int checked = 0;
    int exp_rx = 0;

    nfc_conv dut (.mclk(mclk), .rst_n(rst_n), .in_valid(in_valid), .in_op(in_op),
        .in_data(in_data), .out_valid(out_valid), .out_data(out_data));
    nfc_conv #(.NORM_W(1), .ALPHA_PATH(1'b1), .ROUND_NEAREST(1'b0)) dut2 (.mclk(mclk),
        .rst_n(rst_n),
        .in_valid(in_valid), .in_op(in_op), .in_data(in_data), .out_valid(out_valid2),
        .out_data(out_data2));
    nfc_sink sink (.mclk(mclk), .rst_n(rst_n), .res_valid(out_valid), .res_data(out_data),
        .rx_count(rx_count), .rx_last(rx_last));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("checks=%0d errors=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs

    // reference decode of the small float formats into single precision
    function automatic logic [31:0] dec_small(input logic s, input logic [4:0] e,
        input logic [9:0] m, input int mw);
        int p;
        logic [22:0] mm;
        p = 0;
        mm = 23'(m);
        if (e == 5'h1f) return (m == 10'h0) ? {s, 31'h7f800000} : nfc_pkg::SP_QNAN;
        if (e == 5'h0 && m == 10'h0) return {s, 31'h0};
        if (e != 5'h0) return {s, 8'(e + 112), 23'(mm << (23 - mw))};
        for (int i = 0; i < mw; i++) if (m[i]) p = i;
        return {s, 8'(p + 113 - mw), 23'(mm << (23 - p))};
    endfunction : dec_small

    task automatic send(input logic [3:0] op, input logic [31:0] d, input logic [31:0] ea,
        input logic [31:0] eb);
        @(posedge mclk);
        #1;
        in_valid = 1'b1;
        in_op = op;
        in_data = d;
        exp_a = ea;
        exp_b = eb;
    endtask : send

    task automatic s1(input logic [3:0] op, input logic [31:0] d, input logic [31:0] e);
        send(op, d, e, e);
    endtask : s1

    ////////////////////////////////////////////////////////////////////////////////
    // reference pipeline, two edges deep
    always @(posedge mclk) begin
        pv[0] = rst_n && in_valid;
        po[0] = pv[0] ? in_op : 4'hf;
        pd[0] = pv[0] ? exp_a : 32'h0;
        px[0] = pv[0] ? exp_b : 32'h0;
        for (int k = 2; k > 0; k--) begin
            pv[k] = pv[k-1];
            po[k] = po[k-1];
            pd[k] = pd[k-1];
            px[k] = px[k-1];
        end
    end

    always @(negedge mclk) begin
        if (!rst_n) begin
            pv = '{1'b0, 1'b0, 1'b0};
            po = '{4'hf, 4'hf, 4'hf};
            pd = '{32'h0, 32'h0, 32'h0};
            px = '{32'h0, 32'h0, 32'h0};
            exp_rx = 0;
        end
        if (pv[2]) exp_rx++;
        check({31'h0, out_valid}, {31'h0, pv[2]});
        check({31'h0, out_valid2}, {31'h0, pv[2]});
        check(out_data2, px[2]);
        case (po[2])
            nfc_pkg::OP_DEC_F16: check(out_data, pd[2]);
            nfc_pkg::OP_DEC_F11: check(out_data, pd[2]);
            nfc_pkg::OP_DEC_F10: check(out_data, pd[2]);
            nfc_pkg::OP_ENC_F11: check(out_data, pd[2]);
            nfc_pkg::OP_ENC_F10: check(out_data, pd[2]);
            nfc_pkg::OP_UNORM_TO_F: check(out_data, pd[2]);
            nfc_pkg::OP_SNORM_TO_F: check(out_data, pd[2]);
            nfc_pkg::OP_F_TO_UNORM: check(out_data, pd[2]);
            nfc_pkg::OP_F_TO_SNORM: check(out_data, pd[2]);
            nfc_pkg::OP_FIX_TO_F: check(out_data, pd[2]);
            default: check(out_data, pd[2]);
        endcase
    end

    // hang guard
    initial begin
        #40000;
        bad_count++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [10:0] c11;
        logic [9:0] c10;
        in_valid = 1'b0;
        in_op = 4'h0;
        in_data = 32'h0;
        exp_a = 32'h0;
        exp_b = 32'h0;
        seed = 32'h31;
        rst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        @(posedge mclk);
        s1(nfc_pkg::OP_DEC_F16, 32'h8000, 32'h80000000);
        s1(nfc_pkg::OP_DEC_F16, 32'h0001, 32'h33800000);
        s1(nfc_pkg::OP_DEC_F16, 32'h3c00, 32'h3f800000);
        // random decodes and encode round trips, back to back
        for (int i = 0; i < 200; i++) begin
            seed = xs(seed);
            c11 = 11'(seed[10:0] % 1984);
            c10 = 10'(seed[25:16] % 992);
            s1(nfc_pkg::OP_DEC_F16, {16'h0, seed[15:0]},
                dec_small(seed[15], seed[14:10], seed[9:0], 10));
            s1(nfc_pkg::OP_DEC_F11, {21'h0, seed[26:16]},
                dec_small(1'b0, seed[26:22], {4'h0, seed[21:16]}, 6));
            s1(nfc_pkg::OP_DEC_F10, {22'h0, seed[31:22]},
                dec_small(1'b0, seed[31:27], {5'h0, seed[26:22]}, 5));
            s1(nfc_pkg::OP_ENC_F11, dec_small(1'b0, c11[10:6], {4'h0, c11[5:0]}, 6),
                {21'h0, c11});
            s1(nfc_pkg::OP_ENC_F10, dec_small(1'b0, c10[9:5], {5'h0, c10[4:0]}, 5),
                {22'h0, c10});
        end
        // encoder specials, clamps and a rounding midpoint
        s1(nfc_pkg::OP_ENC_F11, 32'h7f800000, 32'h7c0);
        s1(nfc_pkg::OP_ENC_F11, 32'hff800000, 32'h0);
        s1(nfc_pkg::OP_ENC_F11, 32'h7fc00000, 32'h7e0);
        s1(nfc_pkg::OP_ENC_F11, 32'hffc00001, 32'h7e0);
        s1(nfc_pkg::OP_ENC_F11, 32'h501502f9, 32'h7bf);
        s1(nfc_pkg::OP_ENC_F11, 32'h477e0000, 32'h7bf);
        s1(nfc_pkg::OP_ENC_F11, 32'hbf800000, 32'h0);
        send(nfc_pkg::OP_ENC_F11, 32'h3f810000, 32'h3c1, 32'h3c0);
        s1(nfc_pkg::OP_ENC_F10, 32'h7f800000, 32'h3e0);
        s1(nfc_pkg::OP_ENC_F10, 32'hff800000, 32'h0);
        s1(nfc_pkg::OP_ENC_F10, 32'hffc00000, 32'h3f0);
        s1(nfc_pkg::OP_ENC_F10, 32'h501502f9, 32'h3df);
        s1(nfc_pkg::OP_ENC_F10, 32'h477c0000, 32'h3df);
        s1(nfc_pkg::OP_ENC_F10, 32'hbf800000, 32'h0);
        send(nfc_pkg::OP_ENC_F10, 32'h3f820000, 32'h1e1, 32'h1e0);
        // normalized integers: width eight, and width two on the alpha instance
        send(nfc_pkg::OP_UNORM_TO_F, 32'h00, 32'h0, 32'h0);
        send(nfc_pkg::OP_UNORM_TO_F, 32'hff, 32'h3f800000, 32'h3f800000);
        send(nfc_pkg::OP_UNORM_TO_F, 32'h81, 32'h3f018181, 32'h3eaaaaaa);
        send(nfc_pkg::OP_SNORM_TO_F, 32'h40, 32'h3f010204, 32'h0);
        send(nfc_pkg::OP_SNORM_TO_F, 32'h7f, 32'h3f800000, 32'hbf800000);
        send(nfc_pkg::OP_SNORM_TO_F, 32'h81, 32'hbf800000, 32'h3f800000);
        send(nfc_pkg::OP_SNORM_TO_F, 32'h80, 32'hbf800000, 32'h0);
        send(nfc_pkg::OP_F_TO_UNORM, 32'h3f800000, 32'hff, 32'h3);
        send(nfc_pkg::OP_F_TO_UNORM, 32'h40000000, 32'hff, 32'h3);
        send(nfc_pkg::OP_F_TO_UNORM, 32'hbf800000, 32'h0, 32'h0);
        send(nfc_pkg::OP_F_TO_UNORM, 32'h3e800000, 32'h40, 32'h1);
        send(nfc_pkg::OP_F_TO_UNORM, 32'h7fc00000, 32'h0, 32'h0);
        send(nfc_pkg::OP_F_TO_SNORM, 32'hc0000000, 32'h81, 32'h3);
        send(nfc_pkg::OP_F_TO_SNORM, 32'h3f800000, 32'h7f, 32'h1);
        send(nfc_pkg::OP_F_TO_SNORM, 32'h3e800000, 32'h20, 32'h0);
        send(nfc_pkg::OP_F_TO_SNORM, 32'hbe800000, 32'he0, 32'h0);
        // signed 16.16 fixed point
        s1(nfc_pkg::OP_FIX_TO_F, 32'h00010000, 32'h3f800000);
        s1(nfc_pkg::OP_FIX_TO_F, 32'hffff0000, 32'hbf800000);
        s1(nfc_pkg::OP_FIX_TO_F, 32'h00008000, 32'h3f000000);
        s1(nfc_pkg::OP_FIX_TO_F, 32'h7fff0000, 32'h46fffe00);
        s1(nfc_pkg::OP_FIX_TO_F, 32'h80000000, 32'hc7000000);
        s1(nfc_pkg::OP_FIX_TO_F, 32'h0, 32'h0);
        // unused opcodes still answer with zero
        for (int k = 10; k < 16; k++) begin
            seed = xs(seed);
            s1(4'(k), seed, 32'h0);
        end
        // reset while results are in flight
        s1(nfc_pkg::OP_DEC_F16, 32'h3c00, 32'h3f800000);
        @(posedge mclk);
        #1;
        in_valid = 1'b0;
        rst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        @(posedge mclk);
        s1(nfc_pkg::OP_DEC_F16, 32'hc000, 32'hc0000000);
        @(posedge mclk);
        #1;
        in_valid = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        check(rx_count, 32'(exp_rx));
        check(rx_last, 32'hc0000000);
        final_report();
    end
endmodule : nfc_conv_tb_top
`default_nettype wire
